// [rtl/bwu_pkg.sv]
// Purpose: Constants for the bridge window upper-address register bank.
// Assumes: Configuration accesses are dword wide with byte enables.
// Notes:   Offsets are byte addresses in configuration space.
package bwu_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PREFETCH_WINDOW = 8'h24;
  localparam logic [7:0] OFF_PREFETCH_BOTTOM_HIGH = 8'h28;
  localparam logic [7:0] OFF_PREFETCH_TOP_HIGH = 8'h2C;
  localparam logic [7:0] OFF_IO_HIGH = 8'h30;
  localparam logic [7:0] OFF_CAPABILITY_LIST = 8'h34;
  // ----------------------------------------------------------------
  // Field values
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CAP_32 = 4'h0;
  localparam logic [3:0] ADDR_CAP_64 = 4'h1;
  localparam logic [7:0] CAPABILITY_LIST_START = 8'hB0;
  localparam logic [19:0] LOW_ONES = 20'hFFFFF;
  localparam logic [19:0] LOW_ZEROS = 20'h00000;
  localparam int NUM_WORDS = 5;
  localparam int IDX_BOTTOM_HIGH = 0;
  localparam int IDX_TOP_HIGH = 1;
  localparam int IDX_IO_HIGH = 2;
  localparam int IDX_WINDOW = 3;
  localparam int IDX_NONE = 4;
  // ----------------------------------------------------------------
  // Word images and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] WORD_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] WINDOW_RESET = {12'h000, ADDR_CAP_64, 12'h000, ADDR_CAP_64};
  localparam logic [31:0] WINDOW_WR_MASK = 32'hFFF0_FFF0;
  localparam logic [15:0] IO_LOW_ZEROS = 16'h0000;
  localparam logic [15:0] IO_LOW_ONES = 16'hFFFF;
  localparam int WIN_BOTTOM_MSB = 15;
  localparam int WIN_BOTTOM_LSB = 4;
  localparam int WIN_TOP_MSB = 31;
  localparam int WIN_TOP_LSB = 20;
  localparam int IO_BOTTOM_MSB = 15;
  localparam int IO_BOTTOM_LSB = 0;
  localparam int IO_TOP_MSB = 31;
  localparam int IO_TOP_LSB = 16;
endpackage

// [rtl/bwu_word_reg.sv]
// Purpose: One 32-bit configuration word with byte-enable writes and a write mask.
// Assumes: Synchronous write strobe on clock_i.
// Notes:   Bits outside the mask never change; they hold the reset value.
`timescale 1ns/10ps
module bwu_word_reg #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000,
  parameter logic [31:0] WR_MASK = 32'hFFFF_FFFF
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Write port
  input wire logic wr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  // Stored value
  output logic [31:0] value_o
);
  logic [31:0] value_q;
  logic [31:0] value_d;
  logic [31:0] lane_mask;

  always_comb begin
    lane_mask = {{8{be_i[3]}}, {8{be_i[2]}}, {8{be_i[1]}}, {8{be_i[0]}}} & WR_MASK;
    value_d = value_q;
    if (wr_i) begin
      value_d = (value_q & ~lane_mask) | (wdata_i & lane_mask);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      value_q <= RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_o = value_q;
endmodule

// [rtl/bwu_regs.sv]
// Purpose: Prefetchable window upper address, I/O upper half and capability pointer registers,
//          with the forwarding decision for memory and I/O addresses.
// Assumes: Configuration accesses arrive as one-cycle strobes synchronous to clock_i.
// Notes:   Read data and decode results are registered, one cycle after the request.
`timescale 1ns/10ps

// How it works
// [RULE1] Window-top register bits 19:16 read 0001 (64-bit capable), never writable.
// [RULE2] Window-top bits 31:20 are writable, giving top address bits 31:20.
// [RULE3] Top address bits 19:0 are taken as all ones, ending on 1 MB.
// [RULE4] Register 28h holds bottom bits 63:32, resets zero, used in memory forwarding.
// [RULE5] Register 2Ch holds top bits 63:32, resets zero, used in memory forwarding.
// [RULE6] Register 30h bits 15:0 hold I/O bottom bits 31:16, reset zero.
// [RULE7] Register 30h bits 31:16 hold I/O top bits 31:16, reset zero.
// [RULE8] I/O transactions forward when the address lies in the I/O range.
// [RULE9] Capability pointer at 34h reads fixed B0h.
// [RULE10] Window bits 15:4 hold bottom bits 31:20; bottom bits 19:0 are zero.
// [RULE11] Inclusive 64-bit window compare; writes to read-only fields are dropped.
module bwu_regs (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Configuration access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_hit_o,
  // Forwarding decision
  input wire logic [63:0] mem_addr_i,
  input wire logic [15:0] io_addr_high_i,
  output logic mem_fwd_o,
  output logic io_fwd_o,
  // Decoded window
  output logic [63:0] pf_bottom_o,
  output logic [63:0] pf_top_o
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic int word_index(input logic [7:0] addr);
    case ({addr[7:2], 2'b00})
      bwu_pkg::OFF_PREFETCH_BOTTOM_HIGH: word_index = bwu_pkg::IDX_BOTTOM_HIGH;
      bwu_pkg::OFF_PREFETCH_TOP_HIGH: word_index = bwu_pkg::IDX_TOP_HIGH;
      bwu_pkg::OFF_IO_HIGH: word_index = bwu_pkg::IDX_IO_HIGH;
      bwu_pkg::OFF_PREFETCH_WINDOW: word_index = bwu_pkg::IDX_WINDOW;
      default: word_index = bwu_pkg::IDX_NONE;
    endcase
  endfunction

  // Reset value of each stored word.
  function automatic logic [31:0] word_reset(input int idx);
    case (idx)
      bwu_pkg::IDX_WINDOW: word_reset = bwu_pkg::WINDOW_RESET; // RULE1
      bwu_pkg::IDX_BOTTOM_HIGH: word_reset = bwu_pkg::WORD_ZERO; // RULE4
      bwu_pkg::IDX_TOP_HIGH: word_reset = bwu_pkg::WORD_ZERO; // RULE5
      bwu_pkg::IDX_IO_HIGH: word_reset = bwu_pkg::WORD_ZERO; // RULE6 RULE7
      default: word_reset = bwu_pkg::WORD_ZERO;
    endcase
  endfunction

  // Writable bits of each stored word. The addressing codes in the window word
  // stay fixed, so software always reads back the 64-bit code it expects.
  function automatic logic [31:0] word_mask(input int idx);
    case (idx)
      bwu_pkg::IDX_WINDOW: word_mask = bwu_pkg::WINDOW_WR_MASK; // RULE2 RULE10 RULE11
      bwu_pkg::IDX_BOTTOM_HIGH: word_mask = bwu_pkg::WORD_ONES; // RULE4
      bwu_pkg::IDX_TOP_HIGH: word_mask = bwu_pkg::WORD_ONES; // RULE5
      bwu_pkg::IDX_IO_HIGH: word_mask = bwu_pkg::WORD_ONES; // RULE6 RULE7
      default: word_mask = bwu_pkg::WORD_ZERO; // RULE11
    endcase
  endfunction

  // Inclusive range test, shared by the memory and the I/O decode.
  function automatic logic in_range(input logic [63:0] addr, input logic [63:0] lo,
                                    input logic [63:0] hi);
    in_range = (addr >= lo) && (addr <= hi);
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] word_val [bwu_pkg::NUM_WORDS-1:0];

  // The unmapped slot is last, so the loop stops short of it and spends no flops there.
  genvar gi;
  generate
    for (gi = 0; gi < bwu_pkg::NUM_WORDS - 1; gi++) begin : g_word
      bwu_word_reg #(
        .RESET_VAL(word_reset(gi)),
        .WR_MASK(word_mask(gi))
      ) u_word (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_i(cfg_wr_i && (word_index(cfg_addr_i) == gi)), // RULE2
        .be_i(cfg_be_i),
        .wdata_i(cfg_wdata_i),
        .value_o(word_val[gi])
      );
    end
  endgenerate
  assign word_val[bwu_pkg::IDX_NONE] = bwu_pkg::WORD_ZERO; // RULE11

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  logic [63:0] bottom_c;
  logic [63:0] top_c;
  logic [31:0] io_lo_c;
  logic [31:0] io_hi_c;
  logic [31:0] io_addr_c;

  always_comb begin
    bottom_c = {word_val[bwu_pkg::IDX_BOTTOM_HIGH],
                word_val[bwu_pkg::IDX_WINDOW][bwu_pkg::WIN_BOTTOM_MSB:bwu_pkg::WIN_BOTTOM_LSB],
                bwu_pkg::LOW_ZEROS}; // RULE10 RULE4
    top_c = {word_val[bwu_pkg::IDX_TOP_HIGH],
             word_val[bwu_pkg::IDX_WINDOW][bwu_pkg::WIN_TOP_MSB:bwu_pkg::WIN_TOP_LSB],
             bwu_pkg::LOW_ONES}; // RULE2 RULE3 RULE5
    io_lo_c = {word_val[bwu_pkg::IDX_IO_HIGH][bwu_pkg::IO_BOTTOM_MSB:bwu_pkg::IO_BOTTOM_LSB],
               bwu_pkg::IO_LOW_ZEROS}; // RULE6
    io_hi_c = {word_val[bwu_pkg::IDX_IO_HIGH][bwu_pkg::IO_TOP_MSB:bwu_pkg::IO_TOP_LSB],
               bwu_pkg::IO_LOW_ONES}; // RULE7
    io_addr_c = {io_addr_high_i, bwu_pkg::IO_LOW_ZEROS};
  end

  // ----------------------------------------------------------------
  // Read response
  // ----------------------------------------------------------------
  // Read data stands until the next read, so a master may take it a cycle late.
  // The hit flag lasts one cycle and marks only offsets that this bank owns.
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic hit_q;
  logic hit_d;

  always_comb begin
    rdata_d = rdata_q;
    hit_d = 1'b0;
    if (cfg_rd_i) begin
      if ({cfg_addr_i[7:2], 2'b00} == bwu_pkg::OFF_CAPABILITY_LIST) begin
        rdata_d = {24'h000000, bwu_pkg::CAPABILITY_LIST_START}; // RULE9
        hit_d = 1'b1;
      end else begin
        rdata_d = word_val[word_index(cfg_addr_i)];
        hit_d = (word_index(cfg_addr_i) != bwu_pkg::IDX_NONE);
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= bwu_pkg::WORD_ZERO;
      hit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  // ----------------------------------------------------------------
  // Forwarding decision
  // ----------------------------------------------------------------
  // Registered so the wide compares never reach a pin in the same cycle.
  logic mem_fwd_q;
  logic mem_fwd_d;
  logic io_fwd_q;
  logic io_fwd_d;

  always_comb begin
    mem_fwd_d = in_range(mem_addr_i, bottom_c, top_c); // RULE11 RULE4 RULE5
    // Only the upper 16 bits are held here; the low half is taken as zeros for the bottom and ones for the top.
    io_fwd_d = in_range({bwu_pkg::WORD_ZERO, io_addr_c}, {bwu_pkg::WORD_ZERO, io_lo_c},
                        {bwu_pkg::WORD_ZERO, io_hi_c}); // RULE8
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mem_fwd_q <= 1'b0;
      io_fwd_q <= 1'b0;
    end else begin
      mem_fwd_q <= mem_fwd_d;
      io_fwd_q <= io_fwd_d;
    end
  end

  // ----------------------------------------------------------------
  // Window image
  // ----------------------------------------------------------------
  // The decoded window lags the stored words by one cycle, like the decision.
  logic [63:0] bottom_q;
  logic [63:0] bottom_d;
  logic [63:0] top_q;
  logic [63:0] top_d;

  always_comb begin
    bottom_d = bottom_c;
    top_d = top_c;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bottom_q <= {bwu_pkg::WORD_ZERO, bwu_pkg::WORD_ZERO};
      top_q <= {bwu_pkg::WORD_ZERO, bwu_pkg::WORD_ZERO};
    end else begin
      bottom_q <= bottom_d;
      top_q <= top_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_rdata_o = rdata_q;
  assign cfg_hit_o = hit_q;
  assign mem_fwd_o = mem_fwd_q;
  assign io_fwd_o = io_fwd_q;
  assign pf_bottom_o = bottom_q;
  assign pf_top_o = top_q;
endmodule

// [tb/bwu_peer.sv]
// Purpose: Far-side model presenting transaction addresses to the forwarding decode.
// Assumes: Addresses change only on the falling edge of clock_i.
// Notes: Holds each address until the next request, as a bus master would.
`timescale 1ns/10ps
module bwu_peer (
  // Clock
  input wire logic clock_i,
  // Transaction addresses
  output logic [63:0] mem_addr_o,
  output logic [15:0] io_addr_high_o
);
  initial begin
    mem_addr_o = 64'h0;
    io_addr_high_o = 16'h0;
  end
  task automatic present(input logic [63:0] m, input logic [15:0] io);
    @(negedge clock_i);
    mem_addr_o = m;
    io_addr_high_o = io;
  endtask
endmodule

// [tb/bwu_regs_sva.sv]
// Purpose: Port-level assertions for the window register bank.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes: Bound to every instance of the bank.
`timescale 1ns/10ps
module bwu_regs_sva (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic cfg_hit_o,
  input wire logic [63:0] mem_addr_i,
  input wire logic [63:0] pf_bottom_o,
  input wire logic [63:0] pf_top_o,
  input wire logic mem_fwd_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // The first edge after reset still samples reset-time outputs.
  a_top_ones: assert property (!$past(rst_i) |-> pf_top_o[19:0] == 20'hFFFFF)
    else $error("top low bits not all ones");
  a_bottom_zero: assert property (!$past(rst_i) |-> pf_bottom_o[19:0] == 20'h0)
    else $error("bottom low bits not zero");
  a_cap_ptr: assert property (cfg_rd_i && cfg_addr_i[7:2] == 6'h0D |=>
    cfg_rdata_o[7:0] == 8'hB0 && cfg_hit_o) else $error("capability pointer wrong");
  a_width_code: assert property (cfg_rd_i && cfg_addr_i[7:2] == 6'h09 |=>
    cfg_rdata_o[19:16] == 4'h1) else $error("addressing code wrong");
  a_mem_window: assert property (!$past(rst_i) |-> mem_fwd_o ==
    ($past(mem_addr_i) >= pf_bottom_o && $past(mem_addr_i) <= pf_top_o))
    else $error("memory forward decision wrong");
  a_unmapped_zero: assert property (cfg_rd_i && !(cfg_addr_i[7:2] inside {[6'h09:6'h0D]})
    |=> !cfg_hit_o && cfg_rdata_o == 32'h0) else $error("unmapped read not zero");
  a_top_upper: assert property (cfg_wr_i && cfg_addr_i[7:2] == 6'h0B && cfg_be_i == 4'hF
    |=> ##1 pf_top_o[63:32] == $past(cfg_wdata_i, 2)) else $error("top upper not loaded");
  a_bottom_upper: assert property (cfg_wr_i && cfg_addr_i[7:2] == 6'h0A && cfg_be_i == 4'hF
    |=> ##1 pf_bottom_o[63:32] == $past(cfg_wdata_i, 2)) else $error("bottom upper not loaded");
  a_io_readback: assert property (cfg_wr_i && cfg_addr_i[7:2] == 6'h0C && cfg_be_i == 4'hF
    ##1 !cfg_wr_i ##1 cfg_rd_i && cfg_addr_i[7:2] == 6'h0C && !cfg_wr_i
    |=> cfg_rdata_o == $past(cfg_wdata_i, 3)) else $error("io upper readback wrong");
  c_write: cover property (cfg_wr_i);
  c_mem_fwd: cover property (mem_fwd_o);
  c_hit: cover property (cfg_hit_o);
endmodule
bind bwu_regs bwu_regs_sva u_bwu_regs_sva (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .cfg_wr_i(cfg_wr_i),
  .cfg_rd_i(cfg_rd_i),
  .cfg_addr_i(cfg_addr_i),
  .cfg_be_i(cfg_be_i),
  .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o),
  .cfg_hit_o(cfg_hit_o),
  .mem_addr_i(mem_addr_i),
  .pf_bottom_o(pf_bottom_o),
  .pf_top_o(pf_top_o),
  .mem_fwd_o(mem_fwd_o)
);

// [tb/tb_bwu_regs.sv]
// Purpose: Self-checking bench for the window register bank.
// Assumes: Inputs change on the falling edge of clock_i.
// Notes: Each scenario checks its own results.
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_bwu_regs;
  logic clock_i = 1'b0, rst_i = 1'b1, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
  logic cfg_hit_o, mem_fwd_o, io_fwd_o;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [3:0] cfg_be_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o;
  logic [63:0] mem_addr_i, pf_bottom_o, pf_top_o;
  logic [15:0] io_addr_high_i;
  int n_fail = 0, comparisons = 0, cyc = 0;
  always #4 clock_i = ~clock_i;
  bwu_regs u_bwu_regs (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i),
    .cfg_addr_i(cfg_addr_i),
    .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o),
    .cfg_hit_o(cfg_hit_o),
    .mem_addr_i(mem_addr_i),
    .io_addr_high_i(io_addr_high_i),
    .mem_fwd_o(mem_fwd_o),
    .io_fwd_o(io_fwd_o),
    .pf_bottom_o(pf_bottom_o),
    .pf_top_o(pf_top_o)
  );
  bwu_peer u_bwu_peer (
    .clock_i(clock_i),
    .mem_addr_o(mem_addr_i),
    .io_addr_high_o(io_addr_high_i)
  );
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 600) begin
      n_fail++;
      close_out();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(negedge clock_i);
    {cfg_wr_i, cfg_addr_i, cfg_wdata_i, cfg_be_i} = {1'b1, a, d, be};
    @(negedge clock_i);
    cfg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic h);
    @(negedge clock_i);
    cfg_rd_i = 1'b1;
    cfg_addr_i = a;
    @(negedge clock_i);
    cfg_rd_i = 1'b0;
    `CHK(cfg_rdata_o, e)
    `CHK(cfg_hit_o, h)
  endtask
  task automatic fw(input logic [63:0] m, input logic [15:0] io, input logic em, input logic ei);
    u_bwu_peer.present(m, io);
    @(negedge clock_i);
    `CHK(mem_fwd_o, em)
    `CHK(io_fwd_o, ei)
  endtask
  task automatic t_reset;
    rd(8'h24, 32'h0001_0001, 1'b1);
    rd(8'h28, 32'h0, 1'b1);
    rd(8'h2C, 32'h0, 1'b1);
    rd(8'h30, 32'h0, 1'b1);
    rd(8'h34, 32'h0000_00B0, 1'b1);
    rd(8'h38, 32'h0, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_regs;
    wr(8'h24, 32'hFFFF_FFFF, 4'hF);
    rd(8'h24, 32'hFFF1_FFF1, 1'b1);
    wr(8'h34, 32'h0, 4'hF);
    `CHK(cfg_rdata_o, 32'hFFF1_FFF1)
    rd(8'h34, 32'h0000_00B0, 1'b1);
    wr(8'h28, 32'h1234_5678, 4'h3);
    wr(8'h2C, 32'hCAFE_0001, 4'hC);
    rd(8'h28, 32'h0000_5678, 1'b1);
    `CHK(pf_bottom_o, 64'h0000_5678_FFF0_0000)
    `CHK(pf_top_o, 64'hCAFE_0000_FFFF_FFFF)
    $display("test registers done");
  endtask
  task automatic t_fwd;
    wr(8'h24, 32'h0020_0010, 4'hF);
    wr(8'h28, 32'h1, 4'hF);
    wr(8'h2C, 32'h1, 4'hF);
    wr(8'h30, 32'h0020_0010, 4'hF);
    rd(8'h30, 32'h0020_0010, 1'b1);
    fw(64'h1_000F_FFFF, 16'h000F, 1'b0, 1'b0);
    fw(64'h1_0010_0000, 16'h0010, 1'b1, 1'b1);
    fw(64'h1_002F_FFFF, 16'h0020, 1'b1, 1'b1);
    fw(64'h1_0030_0000, 16'h0021, 1'b0, 1'b0);
    fw(64'h0_0020_0000, 16'h0015, 1'b0, 1'b1);
    $display("test forwarding done");
  endtask
  task automatic t_rst_mid;
    @(negedge clock_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    `CHK(pf_top_o, 64'h0)
    rd(8'h24, 32'h0001_0001, 1'b1);
    rd(8'h28, 32'h0, 1'b1);
    rd(8'h2C, 32'h0, 1'b1);
    rd(8'h30, 32'h0, 1'b1);
    `CHK(pf_top_o, 64'h0000_0000_000F_FFFF)
    `CHK(pf_bottom_o, 64'h0)
    fw(64'h0_000F_FFFF, 16'h0000, 1'b1, 1'b1);
    $display("test mid reset done");
  endtask
  initial begin
    repeat (20) @(negedge clock_i);
    rst_i = 1'b0;
    t_reset();
    t_regs();
    t_fwd();
    t_rst_mid();
    close_out();
  end
endmodule
